// file: src/bqe_pkg.sv
// bqe_pkg: constants for the bus queue event qualifier.
// assumes a single core clock; offsets are byte addresses on the plain register port.
package bqe_pkg;
	// register offsets
	localparam logic [7:0] OFF_SEL_ZERO = 8'h00;
	localparam logic [7:0] OFF_SEL_ONE  = 8'h04;
	localparam logic [7:0] OFF_CFG      = 8'h08;
	localparam logic [7:0] OFF_STATUS   = 8'h0c;
	localparam logic [7:0] OFF_CNT_ZERO = 8'h10;
	localparam logic [7:0] OFF_CNT_ONE  = 8'h14;

	// event selection register layout
	localparam int SEL_CODE_LSB = 25;
	localparam int SEL_CODE_MSB = 31;
	localparam int SEL_MASK_LSB = 9;
	localparam int SEL_MASK_MSB = 24;

	// event codes
	localparam logic [6:0] EV_DATA_ACT   = 7'h17;
	localparam logic [6:0] EV_ACTIVE     = 7'h1a;
	localparam logic [6:0] EV_ALLOC      = 7'h03;

	// mask bit positions inside the 16-bit mask
	localparam int M_RT_LSB   = 0;
	localparam int M_RT_MSB   = 4;
	localparam int M_RD       = 5;
	localparam int M_WR       = 6;
	localparam int M_UC       = 7;
	localparam int M_WC       = 8;
	localparam int M_WT       = 9;
	localparam int M_WP       = 10;
	localparam int M_WB       = 11;
	localparam int M_OWN      = 13;
	localparam int M_OTHER    = 14;
	localparam int M_PREFETCH = 15;
	localparam int M_DRV      = 0;
	localparam int M_SMP      = 1;
	localparam int M_UNSMP    = 2;

	localparam logic [4:0] RT_DEFAULT = 5'h01;

	// memory type codes from the bus queue
	localparam logic [2:0] MT_UC = 3'h0;
	localparam logic [2:0] MT_WC = 3'h1;
	localparam logic [2:0] MT_WT = 3'h2;
	localparam logic [2:0] MT_WP = 3'h3;
	localparam logic [2:0] MT_WB = 3'h4;

	// cfg register bits
	localparam int CFG_MODEL_NEW = 0;
	localparam int CFG_EDGE_ZERO = 1;
	localparam int CFG_EDGE_ONE  = 2;

	// reset values and counts
	localparam logic [31:0] SEL_RESET    = 32'h0000_0000;
	localparam logic [2:0]  CFG_RESET    = 3'h1;
	localparam logic [2:0]  PART_CYCLES  = 3'h2;
	localparam logic [2:0]  FULL_CYCLES  = 3'h4;
	localparam logic [3:0]  ACTIVE_CLIP  = 4'hf;
	localparam logic [4:0]  ACTIVE_MAX   = 5'h1f;

	typedef enum logic {
		bqe_ph_idle,
		bqe_ph_run
	} bqe_ph_state_t;
endpackage

// file: src/bqe_phase_timer.sv
// bqe_phase_timer: stretches a data phase start into a 2 or 4 cycle indication.
// assumes start and flags come from bus interface logic on core_clk.
`timescale 1ns/100ps
module bqe_phase_timer (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic start,
	input  wire logic full,
	input  wire logic drv,
	input  wire logic smp,
	output logic      active,
	output logic      drv_q,
	output logic      smp_q
);
	bqe_pkg::bqe_ph_state_t state;
	bqe_pkg::bqe_ph_state_t next_state;
	logic [2:0]             left;
	logic [2:0]             next_left;
	logic                   next_drv_q;
	logic                   next_smp_q;

	// a new start restarts the window and takes the new flags
	always_comb begin
		next_state = state;
		next_left  = left;
		next_drv_q = drv_q;
		next_smp_q = smp_q;
		case (state)
			bqe_pkg::bqe_ph_idle: begin
				if (start) begin
					next_state = bqe_pkg::bqe_ph_run;
				end
			end
			bqe_pkg::bqe_ph_run: begin
				if (!start && left == 3'h1) begin
					next_state = bqe_pkg::bqe_ph_idle;
				end
			end
			default: next_state = bqe_pkg::bqe_ph_idle;
		endcase
		if (start) begin
			next_left  = full ? bqe_pkg::FULL_CYCLES : bqe_pkg::PART_CYCLES;
			next_drv_q = drv;
			next_smp_q = smp;
		end else if (left != 3'h0) begin
			next_left = left - 3'h1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state  <= bqe_pkg::bqe_ph_idle;
			left   <= 3'h0;
			drv_q  <= 1'b0;
			smp_q  <= 1'b0;
			active <= 1'b0;
		end else begin
			state  <= next_state;
			left   <= next_left;
			drv_q  <= next_drv_q;
			smp_q  <= next_smp_q;
			active <= next_state == bqe_pkg::bqe_ph_run;
		end
	end
endmodule

// file: src/bqe_qualifier.sv
// bqe_qualifier: turns bus queue and data phase activity into counter increments.
// assumes queue signals and data phase signals are produced on core_clk; no pins sampled.
`timescale 1ns/100ps

module bqe_qualifier (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        q_alloc,
	input  wire logic        q_retire,
	input  wire logic [4:0]  q_req_type,
	input  wire logic        q_is_read,
	input  wire logic        q_is_write,
	input  wire logic [2:0]  q_mem_type,
	input  wire logic        q_own,
	input  wire logic        q_is_store,
	input  wire logic        q_prefetch,
	input  wire logic        ph_start,
	input  wire logic        ph_full,
	input  wire logic        ph_drv,
	input  wire logic        ph_smp,
	output logic      [3:0]  evt_inc_zero,
	output logic      [3:0]  evt_inc_one,
	output logic      [3:0]  active_level
);
	logic [31:0] bus_event_select_zero;
	logic [31:0] bus_event_select_one;
	logic [2:0]  cfg;
	logic [31:0] cnt_zero;
	logic [31:0] cnt_one;
	logic [4:0]  active_cnt;
	logic        prev_hit_zero;
	logic        prev_hit_one;
	logic [31:0] next_sel_zero;
	logic [31:0] next_sel_one;
	logic [2:0]  next_cfg;
	logic [31:0] next_cnt_zero;
	logic [31:0] next_cnt_one;
	logic [4:0]  next_active_cnt;
	logic [31:0] next_rdata;
	logic [3:0]  next_inc_zero;
	logic [3:0]  next_inc_one;
	logic [3:0]  next_active_level;
	logic        hit_zero;
	logic        hit_one;
	logic        ind_act;
	logic        ind_drv;
	logic        ind_smp;
	logic        driven_data_ready_qualifier;
	logic        sampled_data_ready_qualifier;
	logic        unsampled_data_ready_qualifier;

	bqe_phase_timer bqe_phase_timer_i (
		.core_clk (core_clk),
		.rst      (rst),
		.start    (ph_start),
		.full     (ph_full),
		.drv      (ph_drv),
		.smp      (ph_smp),
		.active   (ind_act),
		.drv_q    (ind_drv),
		.smp_q    (ind_smp)
	);

	assign driven_data_ready_qualifier    = ind_act & ind_drv;
	assign sampled_data_ready_qualifier   = ind_act & ind_smp;
	assign unsampled_data_ready_qualifier = ind_act & ~ind_smp;

	// queue entry qualification; no privilege input exists, so all levels count
	function automatic logic alloc_hit(input logic [31:0] sel, input logic model_new);
		logic [15:0] m;
		logic        rt_ok;
		logic        rw_ok;
		logic        mem_ok;
		logic        src_ok;
		logic        pf_ok;
		m      = sel[bqe_pkg::SEL_MASK_MSB:bqe_pkg::SEL_MASK_LSB];
		rt_ok  = m[bqe_pkg::M_RT_MSB:bqe_pkg::M_RT_LSB] == bqe_pkg::RT_DEFAULT ||
			m[bqe_pkg::M_RT_MSB:bqe_pkg::M_RT_LSB] == q_req_type;
		rw_ok  = (m[bqe_pkg::M_RD] & q_is_read) | (m[bqe_pkg::M_WR] & q_is_write);
		mem_ok = (m[bqe_pkg::M_UC] && q_mem_type == bqe_pkg::MT_UC) ||
			(m[bqe_pkg::M_WC] && q_mem_type == bqe_pkg::MT_WC) ||
			(m[bqe_pkg::M_WT] && q_mem_type == bqe_pkg::MT_WT) ||
			(m[bqe_pkg::M_WP] && q_mem_type == bqe_pkg::MT_WP) ||
			(m[bqe_pkg::M_WB] && q_mem_type == bqe_pkg::MT_WB);
		src_ok = (m[bqe_pkg::M_OWN] & q_own & q_is_store) |
			(m[bqe_pkg::M_OTHER] & ~q_own);
		pf_ok  = ~q_prefetch | m[bqe_pkg::M_PREFETCH];
		// one allocation is one entry whether a line or a chunk
		if (model_new) begin
			if (m[bqe_pkg::M_RD] | m[bqe_pkg::M_WR]) begin
				mem_ok = 1'b1;
			end
			return q_alloc & pf_ok & rt_ok & rw_ok & mem_ok & src_ok;
		end
		if (m[bqe_pkg::M_RD] | m[bqe_pkg::M_WR]) begin
			mem_ok = 1'b0;
		end
		return q_alloc & pf_ok & (rt_ok | rw_ok | mem_ok) & src_ok;
	endfunction

	function automatic logic data_hit(input logic [31:0] sel);
		logic [15:0] m;
		m = sel[bqe_pkg::SEL_MASK_MSB:bqe_pkg::SEL_MASK_LSB];
		return (m[bqe_pkg::M_DRV] & driven_data_ready_qualifier) |
			(m[bqe_pkg::M_SMP] & sampled_data_ready_qualifier) |
			(m[bqe_pkg::M_UNSMP] & unsampled_data_ready_qualifier);
	endfunction

	function automatic logic sel_hit(input logic [31:0] sel, input logic model_new);
		logic [6:0] code;
		code = sel[bqe_pkg::SEL_CODE_MSB:bqe_pkg::SEL_CODE_LSB];
		if (code == bqe_pkg::EV_DATA_ACT) begin
			return data_hit(sel);
		end else if (code == bqe_pkg::EV_ALLOC) begin
			return alloc_hit(sel, model_new);
		end
		return 1'b0;
	endfunction

	// per-clock increment; active entries pass the clipped level through
	function automatic logic [3:0] inc_value(input logic [31:0] sel, input logic hit,
			input logic prev, input logic edge_mode, input logic [3:0] level);
		if (sel[bqe_pkg::SEL_CODE_MSB:bqe_pkg::SEL_CODE_LSB] == bqe_pkg::EV_ACTIVE) begin
			return level;
		end
		return {3'h0, hit & ~(edge_mode & prev)};
	endfunction

	function automatic logic [3:0] clip_level(input logic [4:0] cnt);
		return (cnt > {1'b0, bqe_pkg::ACTIVE_CLIP}) ? bqe_pkg::ACTIVE_CLIP : cnt[3:0];
	endfunction

	// a process, not an assign, so that queue and indication signals read in the functions wake it
	always_comb begin
		hit_zero = sel_hit(bus_event_select_zero, cfg[bqe_pkg::CFG_MODEL_NEW]);
		hit_one  = sel_hit(bus_event_select_one, cfg[bqe_pkg::CFG_MODEL_NEW]);
	end

	// registers, active entry tracking and counter increments
	always_comb begin
		next_sel_zero   = bus_event_select_zero;
		next_sel_one    = bus_event_select_one;
		next_cfg        = cfg;
		next_rdata      = 32'h0000_0000;
		next_active_cnt = active_cnt;
		if (q_alloc && !q_retire && active_cnt != bqe_pkg::ACTIVE_MAX) begin
			next_active_cnt = active_cnt + 5'h01;
		end else if (q_retire && !q_alloc && active_cnt != 5'h00) begin
			next_active_cnt = active_cnt - 5'h01;
		end
		next_active_level = clip_level(active_cnt);
		next_inc_zero = inc_value(bus_event_select_zero, hit_zero, prev_hit_zero,
			cfg[bqe_pkg::CFG_EDGE_ZERO], next_active_level);
		next_inc_one  = inc_value(bus_event_select_one, hit_one, prev_hit_one,
			cfg[bqe_pkg::CFG_EDGE_ONE], next_active_level);
		next_cnt_zero = cnt_zero + {28'h0000000, evt_inc_zero};
		next_cnt_one  = cnt_one + {28'h0000000, evt_inc_one};
		if (reg_wr) begin
			if (reg_addr == bqe_pkg::OFF_SEL_ZERO) begin
				next_sel_zero = reg_wdata;
			end else if (reg_addr == bqe_pkg::OFF_SEL_ONE) begin
				next_sel_one = reg_wdata;
			end else if (reg_addr == bqe_pkg::OFF_CFG) begin
				next_cfg = reg_wdata[2:0];
			end else if (reg_addr == bqe_pkg::OFF_CNT_ZERO) begin
				next_cnt_zero = reg_wdata;
			end else if (reg_addr == bqe_pkg::OFF_CNT_ONE) begin
				next_cnt_one = reg_wdata;
			end
		end
		if (reg_rd) begin
			if (reg_addr == bqe_pkg::OFF_SEL_ZERO) begin
				next_rdata = bus_event_select_zero;
			end else if (reg_addr == bqe_pkg::OFF_SEL_ONE) begin
				next_rdata = bus_event_select_one;
			end else if (reg_addr == bqe_pkg::OFF_CFG) begin
				next_rdata = {29'h00000000, cfg};
			end else if (reg_addr == bqe_pkg::OFF_STATUS) begin
				next_rdata = {24'h000000, ind_act, ind_drv, ind_smp, active_cnt};
			end else if (reg_addr == bqe_pkg::OFF_CNT_ZERO) begin
				next_rdata = cnt_zero;
			end else if (reg_addr == bqe_pkg::OFF_CNT_ONE) begin
				next_rdata = cnt_one;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bus_event_select_zero <= bqe_pkg::SEL_RESET;
			bus_event_select_one  <= bqe_pkg::SEL_RESET;
			cfg                   <= bqe_pkg::CFG_RESET;
			cnt_zero              <= 32'h0000_0000;
			cnt_one               <= 32'h0000_0000;
			active_cnt            <= 5'h00;
			prev_hit_zero         <= 1'b0;
			prev_hit_one          <= 1'b0;
			reg_rdata             <= 32'h0000_0000;
			evt_inc_zero          <= 4'h0;
			evt_inc_one           <= 4'h0;
			active_level          <= 4'h0;
		end else begin
			bus_event_select_zero <= next_sel_zero;
			bus_event_select_one  <= next_sel_one;
			cfg                   <= next_cfg;
			cnt_zero              <= next_cnt_zero;
			cnt_one               <= next_cnt_one;
			active_cnt            <= next_active_cnt;
			prev_hit_zero         <= hit_zero;
			prev_hit_one          <= hit_one;
			reg_rdata             <= next_rdata;
			evt_inc_zero          <= next_inc_zero;
			evt_inc_one           <= next_inc_one;
			active_level          <= next_active_level;
		end
	end

	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	logic       alloc_sel0;
	logic       data_sel0;
	logic [15:0] m0;
	assign m0         = bus_event_select_zero[bqe_pkg::SEL_MASK_MSB:bqe_pkg::SEL_MASK_LSB];
	assign alloc_sel0 = bus_event_select_zero[31:25] == bqe_pkg::EV_ALLOC;
	assign data_sel0  = bus_event_select_zero[31:25] == bqe_pkg::EV_DATA_ACT;

	property p_part_len;
		ph_start && !ph_full |=> ind_act ##1 ind_act
			##1 (!ind_act || $past(ph_start) || $past(ph_start, 2));
	endproperty
	a_part_len: assert property (p_part_len) else $error("partial indication not two clocks");

	property p_type_miss;
		alloc_sel0 && cfg[0] && q_alloc && m0[4:0] != bqe_pkg::RT_DEFAULT
			&& m0[4:0] != q_req_type |=> evt_inc_zero == 4'h0;
	endproperty
	a_type_miss: assert property (p_type_miss) else $error("type mismatch counted");

	property p_full_len4;
		ph_start && ph_full ##1 (!ph_start) [*4] |=> !ind_act;
	endproperty
	a_full_len4: assert property (p_full_len4) else $error("full indication not four clocks");

	property p_full_run;
		ph_start && ph_full |=> ind_act [*4];
	endproperty
	a_full_run: assert property (p_full_run) else $error("full indication ended early");

	property p_drv_count;
		data_sel0 && m0[0] && driven_data_ready_qualifier && !cfg[1] |=> evt_inc_zero == 4'h1;
	endproperty
	a_drv_count: assert property (p_drv_count) else $error("driven data not counted");

	property p_unsmp;
		data_sel0 && m0 == 16'h0004 && ind_act && ind_smp |=> evt_inc_zero == 4'h0;
	endproperty
	a_unsmp: assert property (p_unsmp) else $error("sampled data counted as unsampled");

	property p_own_store;
		alloc_sel0 && m0[14:13] == 2'b01 && q_own && !q_is_store |=> evt_inc_zero == 4'h0;
	endproperty
	a_own_store: assert property (p_own_store) else $error("own non-store counted");

	property p_other;
		alloc_sel0 && cfg[0] && q_alloc && !q_own && m0[14] && (m0[15] || !q_prefetch)
			&& m0[5] && q_is_read && m0[4:0] == 5'h01 && !cfg[1] |=> evt_inc_zero == 4'h1;
	endproperty
	a_other: assert property (p_other) else $error("other agent read not counted");

	property p_level;
		##1 active_level == (($past(active_cnt) > 5'h0f) ? 4'hf : $past(active_cnt[3:0]));
	endproperty
	a_level: assert property (p_level) else $error("active level wrong");

	property p_edge;
		cfg[1] && prev_hit_zero && hit_zero |=> evt_inc_zero == 4'h0;
	endproperty
	a_edge: assert property (p_edge) else $error("edge mode counted a held trigger");

	c_full: cover property (ph_start && ph_full ##1 ind_act [*4]);
	c_alloc: cover property (alloc_sel0 && hit_zero);
	c_clip: cover property (active_cnt > 5'h10 && active_level == 4'hf);
endmodule

// file: verif/bqe_bus_agent.sv
// bqe_bus_agent: behavioural bus agents that feed the queue and data phase inputs.
// assumes core_clk from the bench; the bench calls its tasks by hierarchical name.
`timescale 1ns/100ps
module bqe_bus_agent (
	input  wire logic       core_clk,
	output logic            q_alloc,
	output logic            q_retire,
	output logic      [4:0] q_req_type,
	output logic            q_is_read,
	output logic            q_is_write,
	output logic      [2:0] q_mem_type,
	output logic            q_own,
	output logic            q_is_store,
	output logic            q_prefetch,
	output logic            ph_start,
	output logic            ph_full,
	output logic            ph_drv,
	output logic            ph_smp
);
	initial begin
		{q_alloc, q_retire, q_req_type, q_is_read, q_is_write} = '0;
		{q_mem_type, q_own, q_is_store, q_prefetch} = '0;
		{ph_start, ph_full, ph_drv, ph_smp} = '0;
	end

	// one entry per call; own=0 stands for another processor or a dma agent
	task automatic alloc(input logic [4:0] rt, input logic rd, input logic wr,
			input logic [2:0] mt, input logic own, input logic st, input logic pf);
		@(posedge core_clk);
		q_alloc <= 1'b1;
		{q_req_type, q_is_read, q_is_write} <= {rt, rd, wr};
		{q_mem_type, q_own, q_is_store, q_prefetch} <= {mt, own, st, pf};
		@(posedge core_clk);
		q_alloc <= 1'b0;
		// fields are no longer valid: show their inverse
		{q_req_type, q_is_read, q_is_write} <= ~{rt, rd, wr};
		{q_mem_type, q_own, q_is_store, q_prefetch} <= ~{mt, own, st, pf};
	endtask

	task automatic retire();
		@(posedge core_clk);
		q_retire <= 1'b1;
		@(posedge core_clk);
		q_retire <= 1'b0;
	endtask

	task automatic phase(input logic full, input logic drv, input logic smp);
		@(posedge core_clk);
		ph_start <= 1'b1;
		{ph_full, ph_drv, ph_smp} <= {full, drv, smp};
		@(posedge core_clk);
		ph_start <= 1'b0;
		{ph_full, ph_drv, ph_smp} <= ~{full, drv, smp};
	endtask
endmodule

// file: verif/tb_bqe_qualifier.sv
// tb_bqe_qualifier: self-checking bench for the bus queue event qualifier.
// assumes the bus agent model drives all queue and data phase inputs.
`timescale 1ns/100ps
module tb_bqe_qualifier;
	logic        core_clk;
	logic        rst;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        q_alloc, q_retire, q_is_read, q_is_write, q_own, q_is_store, q_prefetch;
	logic [4:0]  q_req_type;
	logic [2:0]  q_mem_type;
	logic        ph_start, ph_full, ph_drv, ph_smp;
	logic [3:0]  evt_inc_zero, evt_inc_one, active_level;
	int          err_total;
	int          checked;
	int          cycles;
	logic [31:0] rv;

	bqe_qualifier bqe_qualifier_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.q_alloc(q_alloc), .q_retire(q_retire), .q_req_type(q_req_type),
		.q_is_read(q_is_read), .q_is_write(q_is_write), .q_mem_type(q_mem_type),
		.q_own(q_own), .q_is_store(q_is_store), .q_prefetch(q_prefetch),
		.ph_start(ph_start), .ph_full(ph_full), .ph_drv(ph_drv), .ph_smp(ph_smp),
		.evt_inc_zero(evt_inc_zero), .evt_inc_one(evt_inc_one), .active_level(active_level));

	bqe_bus_agent bqe_bus_agent_i (.core_clk(core_clk), .q_alloc(q_alloc),
		.q_retire(q_retire), .q_req_type(q_req_type), .q_is_read(q_is_read),
		.q_is_write(q_is_write), .q_mem_type(q_mem_type), .q_own(q_own),
		.q_is_store(q_is_store), .q_prefetch(q_prefetch), .ph_start(ph_start),
		.ph_full(ph_full), .ph_drv(ph_drv), .ph_smp(ph_smp));

	always #5 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("counts: %0d compared, %0d mismatched", checked, err_total);
		if (err_total == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	function automatic logic [31:0] sel(input logic [6:0] code, input logic [15:0] mask);
		return {code, mask, 9'h000};
	endfunction

	task automatic sel_both(input logic [15:0] mask);
		reg_write(bqe_pkg::OFF_SEL_ZERO, sel(bqe_pkg::EV_ALLOC, mask));
		reg_write(bqe_pkg::OFF_SEL_ONE, sel(bqe_pkg::EV_ALLOC, mask));
	endtask

	task automatic sel_data(input logic [15:0] mask);
		reg_write(bqe_pkg::OFF_SEL_ZERO, sel(bqe_pkg::EV_DATA_ACT, mask));
		reg_write(bqe_pkg::OFF_SEL_ONE, sel(bqe_pkg::EV_DATA_ACT, mask));
	endtask

	// rw = {read, write}, osp = {own, store, prefetch}
	task automatic q_case(input logic [4:0] rt, input logic [1:0] rw, input logic [2:0] mt,
			input logic [2:0] osp, input logic [3:0] exp);
		bqe_bus_agent_i.alloc(rt, rw[1], rw[0], mt, osp[2], osp[1], osp[0]);
		#1;
		chk("evt_inc_zero", evt_inc_zero, exp);
		chk("evt_inc_one", evt_inc_one, exp);
	endtask

	// fds = {full, drv, smp}; sums the data activity increments over the window
	task automatic d_case(input logic [2:0] fds, input logic [31:0] exp);
		logic [31:0] s;
		logic [31:0] s0;
		s = '0;
		s0 = '0;
		bqe_bus_agent_i.phase(fds[2], fds[1], fds[0]);
		for (int i = 0; i < 8; i++) begin
			#1;
			s = s + 32'(evt_inc_one);
			s0 = s0 + 32'(evt_inc_zero);
			@(posedge core_clk);
		end
		chk("data activity sum one", s, exp);
		chk("data activity sum zero", s0, exp);
	endtask

	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{err_total, checked, cycles} = '0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;

		reg_read(bqe_pkg::OFF_SEL_ZERO, rv);
		chk("sel_zero reset", rv, bqe_pkg::SEL_RESET);
		reg_read(bqe_pkg::OFF_CFG, rv);
		chk("cfg reset", rv, 32'(bqe_pkg::CFG_RESET));
		reg_write(8'h20, 32'hffff_ffff);
		reg_read(8'h20, rv);
		chk("unmapped read", rv, 32'h0);
		reg_write(bqe_pkg::OFF_SEL_ONE, 32'h1234_5600);
		reg_read(bqe_pkg::OFF_SEL_ONE, rv);
		chk("sel_one readback", rv, 32'h1234_5600);
		$display("test registers done");

		reg_write(bqe_pkg::OFF_SEL_ZERO, sel(bqe_pkg::EV_ACTIVE, 16'h0000));
		repeat (17) bqe_bus_agent_i.alloc(5'h01, 1'b1, 1'b0, bqe_pkg::MT_WB, 1'b0, 1'b0, 1'b0);
		repeat (2) @(posedge core_clk);
		#1;
		chk("active_level clip", active_level, 32'hf);
		chk("evt_inc_zero active", evt_inc_zero, 32'hf);
		reg_write(bqe_pkg::OFF_STATUS, 32'h0);
		reg_read(bqe_pkg::OFF_STATUS, rv);
		chk("status count", rv[4:0], 32'd17);
		repeat (3) bqe_bus_agent_i.retire();
		repeat (2) @(posedge core_clk);
		#1;
		chk("active_level", active_level, 32'he);
		repeat (14) bqe_bus_agent_i.retire();
		$display("test active entries done");

		reg_write(bqe_pkg::OFF_CFG, 32'h0);
		sel_both(16'h4403);
		q_case(5'h02, 2'b10, bqe_pkg::MT_WP, 3'b000, 4'h1);
		q_case(5'h02, 2'b10, bqe_pkg::MT_WB, 3'b000, 4'h0);
		q_case(5'h02, 2'b10, bqe_pkg::MT_WP, 3'b100, 4'h0);
		q_case(5'h02, 2'b10, bqe_pkg::MT_WP, 3'b001, 4'h0);
		sel_both(16'h4803);
		q_case(5'h02, 2'b01, bqe_pkg::MT_WB, 3'b000, 4'h1);
		q_case(5'h02, 2'b01, bqe_pkg::MT_WP, 3'b000, 4'h0);
		sel_both(16'hc403);
		q_case(5'h02, 2'b10, bqe_pkg::MT_WP, 3'b001, 4'h1);
		sel_both(16'h2403);
		q_case(5'h02, 2'b01, bqe_pkg::MT_WP, 3'b110, 4'h1);
		q_case(5'h02, 2'b10, bqe_pkg::MT_WP, 3'b100, 4'h0);
		q_case(5'h02, 2'b01, bqe_pkg::MT_WP, 3'b010, 4'h0);
		sel_both(16'h4002);
		q_case(5'h02, 2'b10, bqe_pkg::MT_UC, 3'b000, 4'h1);
		q_case(5'h05, 2'b10, bqe_pkg::MT_UC, 3'b000, 4'h0);
		sel_both(16'h4423);
		q_case(5'h02, 2'b01, bqe_pkg::MT_WP, 3'b000, 4'h0);
		$display("test older model done");

		reg_write(bqe_pkg::OFF_CFG, 32'h1);
		sel_both(16'h4021);
		reg_write(bqe_pkg::OFF_CNT_ZERO, 32'h0);
		q_case(5'h07, 2'b10, bqe_pkg::MT_UC, 3'b000, 4'h1);
		q_case(5'h07, 2'b01, bqe_pkg::MT_UC, 3'b000, 4'h0);
		q_case(5'h07, 2'b10, bqe_pkg::MT_UC, 3'b100, 4'h0);
		q_case(5'h03, 2'b10, bqe_pkg::MT_WB, 3'b000, 4'h1);
		reg_read(bqe_pkg::OFF_CNT_ZERO, rv);
		chk("counter zero", rv, 32'h2);
		sel_both(16'h4023);
		q_case(5'h02, 2'b10, bqe_pkg::MT_WB, 3'b000, 4'h0);
		q_case(5'h03, 2'b10, bqe_pkg::MT_WB, 3'b000, 4'h1);
		$display("test newer model done");

		sel_data(16'h0001);
		d_case(3'b010, 32'd2);
		d_case(3'b110, 32'd4);
		d_case(3'b101, 32'd0);
		sel_data(16'h0002);
		d_case(3'b101, 32'd4);
		d_case(3'b001, 32'd2);
		d_case(3'b010, 32'd0);
		sel_data(16'h0004);
		d_case(3'b110, 32'd4);
		d_case(3'b000, 32'd2);
		d_case(3'b101, 32'd0);
		reg_write(bqe_pkg::OFF_CFG, 32'h7);
		sel_data(16'h0001);
		d_case(3'b110, 32'd1);
		$display("test data activity done");

		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		reg_read(bqe_pkg::OFF_CFG, rv);
		chk("cfg after reset", rv, 32'(bqe_pkg::CFG_RESET));
		reg_read(bqe_pkg::OFF_CNT_ONE, rv);
		chk("counter one after reset", rv, 32'h0);
		$display("test mid-run reset done");
		give_verdict();
	end
endmodule
